// file: core/tmsf_limit_cmp.sv
`timescale 1ns/1ps
module tmsf_limit_cmp #(
    parameter int W = 8
) (
    input wire logic [W-1:0] i_value,  // current reading
    input wire logic [W-1:0] i_low,    // low limit
    input wire logic [W-1:0] i_high,   // high limit
    output logic o_violation           // reading out of limits
);
    // high is strictly above, low includes equality
    assign o_violation = (i_value > i_high) || (i_value <= i_low); // RULE13
endmodule

// file: core/tmsf_pkg.sv
package tmsf_pkg;
    // register offsets on the management bus
    localparam logic [7:0] TMSF_ADDR_PRIMARY = 8'h41;
    localparam logic [7:0] TMSF_ADDR_SECONDARY = 8'h42;
    localparam logic [7:0] TMSF_FLAGS_RESET = 8'h00;
    localparam logic [7:0] TMSF_READ_UNMAPPED = 8'h00;
    // widths of readings and tachometer counts
    localparam int TMSF_MEAS_W = 8;
    localparam int TMSF_TACH_W = 16;
    localparam int TMSF_TIME_W = 8;
    localparam int TMSF_NUM_MEAS = 5;
    localparam int TMSF_NUM_FANS = 4;
    // primary register bit positions
    localparam int TMSF_PRI_PROC_SUPPLY = 1;
    localparam int TMSF_PRI_MAIN_SUPPLY = 2;
    localparam int TMSF_PRI_FIRST_REMOTE = 4;
    localparam int TMSF_PRI_LOCAL = 5;
    localparam int TMSF_PRI_SECOND_REMOTE = 6;
    localparam int TMSF_PRI_SUMMARY = 7;
    // measurement channel index to primary bit position
    localparam int TMSF_PRI_POS [TMSF_NUM_MEAS] = '{
        TMSF_PRI_PROC_SUPPLY, TMSF_PRI_MAIN_SUPPLY, TMSF_PRI_FIRST_REMOTE,
        TMSF_PRI_LOCAL, TMSF_PRI_SECOND_REMOTE};
    // secondary register bit positions
    localparam int TMSF_SEC_OVERTEMP = 1;
    localparam int TMSF_SEC_FIRST_FAN = 2;
    localparam int TMSF_SEC_SHARED_PIN = 5;
    localparam int TMSF_SEC_FIRST_DIODE = 6;
    localparam int TMSF_SEC_SECOND_DIODE = 7;
    // function of the shared pin behind bit 5
    typedef enum logic [1:0] {
        TMSF_PIN_TACH = 2'b00,
        TMSF_PIN_GPIO = 2'b01,
        TMSF_PIN_TIMER = 2'b10,
        TMSF_PIN_UNUSED = 2'b11
    } tmsf_pin_mode_t;
endpackage

// file: core/tmsf_status_flags.sv
`timescale 1ns/1ps
// What this block does
// RULE1: both status registers are zero after reset.
// RULE2: bit 1 flags processor supply, bit 2 main supply out of limits.
// RULE3: bits 4, 5, 6 flag first remote, local, second remote temperature.
// RULE4: reading the first register clears flags only when their cause is gone.
// RULE5: first register bit 7 is the OR of all second register bits.
// RULE6: second register bit 1 flags overtemperature, clears below limit minus hysteresis.
// RULE7: second register bits 2, 3, 4 flag slow or stalled fans 1 to 3.
// RULE8: a fan flag is not set while its drive output is off.
// RULE9: in tach mode bit 5 flags fan 4, suppressed while third drive off.
// RULE10: in output mode bit 5 is writable and drives the pin level.
// RULE11: in timer mode bit 5 sets when assertion time exceeds its limit.
// RULE12: bits 6 and 7 flag open or short on first and second diode.
// RULE13: high violation is reading above limit, low is reading at or below.
// RULE14: a tach count above its minimum-speed limit means slow fan.
// RULE15: undefined bit positions read zero and ignore writes.
module tmsf_status_flags
    import tmsf_pkg::*;
#(
    parameter int MEAS_W = TMSF_MEAS_W,
    parameter int TACH_W = TMSF_TACH_W,
    parameter int TIME_W = TMSF_TIME_W
) (
    input wire logic i_sys_clk,                                  // system clock
    input wire logic i_sys_rst,                                  // sync reset, high
    input wire logic i_clk_en,                                   // freezes state when low
    input wire logic [7:0] i_reg_addr,                           // register offset
    input wire logic i_reg_rd,                                   // read strobe
    input wire logic i_reg_wr,                                   // write strobe
    input wire logic [7:0] i_reg_wdata,                          // write data
    output logic [7:0] o_reg_rdata,                              // read data
    output logic o_reg_rvalid,                                   // read data valid
    input wire logic [TMSF_NUM_MEAS-1:0][MEAS_W-1:0] i_meas,     // supply and temp readings
    input wire logic [TMSF_NUM_MEAS-1:0][MEAS_W-1:0] i_meas_low, // low limits
    input wire logic [TMSF_NUM_MEAS-1:0][MEAS_W-1:0] i_meas_high,// high limits
    input wire logic [TMSF_NUM_FANS-1:0][TACH_W-1:0] i_tach,     // tach counts
    input wire logic [TMSF_NUM_FANS-1:0][TACH_W-1:0] i_tach_min, // minimum-speed limits
    input wire logic [2:0] i_drive_on,                           // drive outputs 1 to 3 on
    input wire logic i_overtemp_exceeded,                        // above overtemp limit
    input wire logic i_overtemp_below_hyst,                      // below limit minus hyst
    input wire logic [1:0] i_pin_mode,                           // shared pin function
    input wire logic [TIME_W-1:0] i_overtemp_time,               // measured assertion time
    input wire logic [TIME_W-1:0] i_overtemp_time_limit,         // time limit setting
    input wire logic i_first_diode_fault,                        // diode 1 open or short
    input wire logic i_second_diode_fault,                       // diode 2 open or short
    output logic o_gpio_level                                    // shared pin output level
);
    logic [7:0] pri_q;
    logic [7:0] pri_d;
    logic [7:0] sec_q;
    logic [7:0] sec_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic gpio_q;
    logic gpio_d;
    logic [TMSF_NUM_MEAS-1:0] meas_viol;
    logic [TMSF_NUM_FANS-1:0] fan_slow;
    logic rd_pri;
    logic rd_sec;
    logic wr_sec;
    logic timer_over;
    tmsf_pin_mode_t pin_mode;

    assign pin_mode = tmsf_pin_mode_t'(i_pin_mode);
    assign rd_pri = i_reg_rd && (i_reg_addr == TMSF_ADDR_PRIMARY);
    assign rd_sec = i_reg_rd && (i_reg_addr == TMSF_ADDR_SECONDARY);
    assign wr_sec = i_reg_wr && (i_reg_addr == TMSF_ADDR_SECONDARY);
    assign timer_over = i_overtemp_time > i_overtemp_time_limit; // RULE11

    // limit comparators and tach checks per channel
    generate
        for (genvar g = 0; g < TMSF_NUM_MEAS; g++) begin : g_meas
            tmsf_limit_cmp #(
                .W(MEAS_W)
            ) u_cmp (
                .i_value(i_meas[g]),
                .i_low(i_meas_low[g]),
                .i_high(i_meas_high[g]),
                .o_violation(meas_viol[g])
            );
        end
        for (genvar f = 0; f < TMSF_NUM_FANS; f++) begin : g_fan
            // fan 4 shares the third drive output with fan 3
            localparam int DRV = (f < 3) ? f : 2;
            assign fan_slow[f] = (i_tach[f] > i_tach_min[f]) && i_drive_on[DRV]; // RULE14 RULE8
        end
    endgenerate

    // primary flags, set wins over clear on read
    always_comb begin
        pri_d = pri_q;
        // a cause present in the read cycle keeps its flag
        for (int i = 0; i < TMSF_NUM_MEAS; i++) begin
            pri_d[TMSF_PRI_POS[i]] = meas_viol[i] |
                (pri_q[TMSF_PRI_POS[i]] & ~rd_pri); // RULE2 RULE3 RULE4
        end
        // undefined positions and summary are never stored
        pri_d[0] = 1'h0; // RULE15
        pri_d[3] = 1'h0; // RULE15
        pri_d[TMSF_PRI_SUMMARY] = 1'h0; // rebuilt live on read
    end

    // primary flag register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pri_q <= TMSF_FLAGS_RESET; // RULE1
        end else if (i_clk_en) begin
            pri_q <= pri_d;
        end
    end

    // secondary flags latched until a read finds the cause gone, except bit 5 in output mode (written) and unused mode (clear)
    always_comb begin
        sec_d = sec_q;
        // overtemp clears on read only below the hysteresis point
        sec_d[TMSF_SEC_OVERTEMP] = i_overtemp_exceeded |
            (sec_q[TMSF_SEC_OVERTEMP] & ~(rd_sec & i_overtemp_below_hyst)); // RULE6
        // fans 1 to 3, already gated by their drive outputs
        for (int k = 0; k < 3; k++) begin
            sec_d[TMSF_SEC_FIRST_FAN+k] = fan_slow[k] |
                (sec_q[TMSF_SEC_FIRST_FAN+k] & ~rd_sec); // RULE7 RULE8
        end
        // shared pin bit, meaning set by the pin function
        case (pin_mode)
            TMSF_PIN_TACH: begin
                // fan 4 slow flag
                sec_d[TMSF_SEC_SHARED_PIN] = fan_slow[3] |
                    (sec_q[TMSF_SEC_SHARED_PIN] & ~rd_sec); // RULE9
            end
            TMSF_PIN_GPIO: begin
                // plain storage, reads leave it alone
                if (wr_sec) begin
                    sec_d[TMSF_SEC_SHARED_PIN] = i_reg_wdata[TMSF_SEC_SHARED_PIN]; // RULE10
                end
            end
            TMSF_PIN_TIMER: begin
                // overtemp assertion time over its limit
                sec_d[TMSF_SEC_SHARED_PIN] = timer_over |
                    (sec_q[TMSF_SEC_SHARED_PIN] & ~rd_sec); // RULE11
            end
            default: begin
                // pin unused, bit held clear
                sec_d[TMSF_SEC_SHARED_PIN] = 1'h0;
            end
        endcase
        // diode faults
        sec_d[TMSF_SEC_FIRST_DIODE] = i_first_diode_fault |
            (sec_q[TMSF_SEC_FIRST_DIODE] & ~rd_sec); // RULE12
        sec_d[TMSF_SEC_SECOND_DIODE] = i_second_diode_fault |
            (sec_q[TMSF_SEC_SECOND_DIODE] & ~rd_sec); // RULE12
        // undefined position
        sec_d[0] = 1'h0; // RULE15
    end

    // secondary flag register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            sec_q <= TMSF_FLAGS_RESET; // RULE1
        end else if (i_clk_en) begin
            sec_q <= sec_d;
        end
    end

    // read port, data captured before the clear takes effect
    always_comb begin
        rdata_d = rdata_q; // holds until the next read
        rvalid_d = 1'h0;
        if (i_reg_rd) begin
            rvalid_d = 1'h1;
            case (i_reg_addr)
                TMSF_ADDR_PRIMARY: begin
                    // summary rebuilt from the live secondary flags
                    rdata_d = pri_q;
                    rdata_d[TMSF_PRI_SUMMARY] = |sec_q; // RULE5
                end
                TMSF_ADDR_SECONDARY: begin
                    rdata_d = sec_q;
                end
                default: begin
                    // an unmapped offset still answers, with zeros
                    rdata_d = TMSF_READ_UNMAPPED;
                end
            endcase
        end
    end

    // read port registers
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rdata_q <= TMSF_FLAGS_RESET;
            rvalid_q <= 1'h0;
        end else if (i_clk_en) begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // pin level follows the stored bit in output mode only
    always_comb begin
        gpio_d = 1'h0;
        if (pin_mode == TMSF_PIN_GPIO) begin
            gpio_d = sec_d[TMSF_SEC_SHARED_PIN]; // RULE10
        end
    end

    // pin level register, moves on the same edge as the bit
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            gpio_q <= 1'h0;
        end else if (i_clk_en) begin
            gpio_q <= gpio_d;
        end
    end

    // outputs straight from the registers
    assign o_reg_rdata = rdata_q;
    assign o_reg_rvalid = rvalid_q;
    assign o_gpio_level = gpio_q;
endmodule

// file: tb/tmsf_host_model.sv
`timescale 1ns/1ps
// host side: one register access per call on the strobes
module tmsf_host_model (
    input wire logic i_sys_clk, // clock
    output logic [7:0] o_addr, // offset
    output logic o_rd, // read strobe
    output logic o_wr, // write strobe
    output logic [7:0] o_wdata // write data
);
    initial {o_addr, o_rd, o_wr, o_wdata} = 18'h00000;
    // strobe for one cycle, then scramble the released data
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
        @(negedge i_sys_clk);
        {o_wr, o_rd, o_wdata} = {2'b00, ~d};
    endtask
endmodule

// file: tb/tmsf_status_flags_asserts.sv
`timescale 1ns/1ps
// port-level checks on the status flag registers
module tmsf_status_flags_asserts #(
    parameter int TIME_W = 8
) (
    input wire logic i_sys_clk, // clock
    input wire logic i_sys_rst, // reset
    input wire logic i_clk_en, // enable
    input wire logic [7:0] i_reg_addr, // offset
    input wire logic i_reg_rd, // read strobe
    input wire logic i_reg_wr, // write strobe
    input wire logic [7:0] i_reg_wdata, // write data
    input wire logic [1:0] i_pin_mode, // pin mode
    input wire logic [TIME_W-1:0] i_overtemp_time, // time
    input wire logic [TIME_W-1:0] i_overtemp_time_limit, // limit
    input wire logic i_first_diode_fault, // diode 1
    input wire logic i_second_diode_fault, // diode 2
    input wire logic [7:0] o_reg_rdata, // read data
    input wire logic o_reg_rvalid, // read valid
    input wire logic o_gpio_level // pin level
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // read answers, reset state and set paths
    AST_RST_ZERO: assert property ($fell(i_sys_rst) |-> !o_reg_rvalid && o_reg_rdata == 8'h00)
        else $error("outputs not clear after reset");
    AST_RVALID: assert property (i_reg_rd && i_clk_en |=> o_reg_rvalid)
        else $error("read got no answer");
    AST_NO_RVALID: assert property (i_clk_en && !i_reg_rd |=> !o_reg_rvalid)
        else $error("answer without read");
    AST_FREEZE: assert property (!i_clk_en |=> $stable(o_reg_rvalid)
        && $stable(o_reg_rdata) && $stable(o_gpio_level)) else $error("outputs moved while frozen");
    AST_UNDEF_BITS: assert property (o_reg_rvalid |-> !o_reg_rdata[0]
        && ($past(i_reg_addr) != 8'h41 || !o_reg_rdata[3])) else $error("undefined bit set");
    AST_DIODE_SET: assert property (o_reg_rvalid && $past(i_reg_addr) == 8'h42
        && $past(i_second_diode_fault, 2) && $past(i_clk_en, 2) && !$past(i_sys_rst, 2)
        && $past(i_clk_en) |-> o_reg_rdata[7]) else $error("diode flag missing");
    AST_SUMMARY: assert property (o_reg_rvalid && $past(i_reg_addr) == 8'h41
        && $past(i_first_diode_fault, 2) && $past(i_clk_en, 2) && !$past(i_sys_rst, 2)
        && $past(i_clk_en) |-> o_reg_rdata[7]) else $error("summary bit missing");
    AST_TIMER_SET: assert property (o_reg_rvalid && $past(i_reg_addr) == 8'h42
        && $past(i_pin_mode, 2) == 2'b10 && $past(i_pin_mode) == 2'b10 && $past(i_clk_en, 2)
        && !$past(i_sys_rst, 2) && $past(i_overtemp_time, 2) > $past(i_overtemp_time_limit, 2)
        && $past(i_clk_en) |-> o_reg_rdata[5]) else $error("timer flag missing");
    AST_GPIO_WR: assert property (i_reg_wr && i_clk_en && i_reg_addr == 8'h42
        && i_pin_mode == 2'b01 |=> o_gpio_level == $past(i_reg_wdata[5]))
        else $error("pin level not written");
    AST_GPIO_OFF: assert property (i_pin_mode != 2'b01 && i_clk_en |=> !o_gpio_level)
        else $error("pin driven outside output mode");
endmodule

// file: tb/tmsf_status_flags_bench.sv
`timescale 1ns/1ps
module tmsf_status_flags_bench;
    import tmsf_pkg::*;
    logic clk = 0, rst = 1, en = 1, ovx = 0, ovh = 0, d1 = 0, d2 = 0, rd_s, wr_s, rv, gpio;
    logic [4:0][7:0] meas = {5{8'h80}}, lo = {5{8'h10}}, hi = {5{8'hF0}};
    logic [3:0][15:0] tach = {4{16'h1000}}, tmin = {4{16'h8000}};
    logic [2:0] drv = 3'b111;
    logic [1:0] mode = 2'b00;
    logic [7:0] tm = 8'h00, tl = 8'h00, addr, wdata, rdata, v;
    logic [7:0] exp_q[$];
    int mismatches = 0, checks = 0, cyc = 0, seed;
    always #4 clk = ~clk;
    tmsf_host_model tmsf_host_model_inst (.i_sys_clk(clk), .o_addr(addr), .o_rd(rd_s),
        .o_wr(wr_s), .o_wdata(wdata));
    tmsf_status_flags tmsf_status_flags_inst (.i_sys_clk(clk), .i_sys_rst(rst),
        .i_clk_en(en), .i_reg_addr(addr), .i_reg_rd(rd_s), .i_reg_wr(wr_s),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rv), .i_meas(meas),
        .i_meas_low(lo), .i_meas_high(hi), .i_tach(tach), .i_tach_min(tmin),
        .i_drive_on(drv), .i_overtemp_exceeded(ovx), .i_overtemp_below_hyst(ovh),
        .i_pin_mode(mode), .i_overtemp_time(tm), .i_overtemp_time_limit(tl),
        .i_first_diode_fault(d1), .i_second_diode_fault(d2), .o_gpio_level(gpio));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // shared pin level against its expected value
    task automatic chk_gpio(input logic e);
        checks++;
        if (gpio !== e) begin
            mismatches++;
            $display("CHECK FAILED gpio expected %b seen %b", e, gpio);
        end
    endtask
    // note the expected byte, then strobe the read
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        tmsf_host_model_inst.access(1'b0, a, 8'h00);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watcher: each answer against the oldest note
    always @(negedge clk) if (rv === 1'b1) chk("rdata", exp_q.pop_front(), rdata);
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        seed = $urandom(32'h095A);
        repeat (20) @(negedge clk);
        rst = 0;
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 5; i++) begin
            v = 8'h11 + 8'($urandom_range(0, 223));
            @(negedge clk) meas[i] = (i % 2) ? 8'hF1 : 8'h10;
            // hold the reading on the boundary that is still in limits
            @(negedge clk) meas[i] = (i % 2) ? 8'hF0 : 8'h11;
            rd(8'h41, 8'h01 << TMSF_PRI_POS[i]);
            rd(8'h41, 8'h00);
            meas[i] = v;
        end
        meas[0] = 8'hF1;
        rd(8'h41, 8'h02);
        meas[0] = 8'h80;
        rd(8'h41, 8'h02);
        rd(8'h41, 8'h00);
        $display("reading test done");
        for (int f = 0; f < 4; f++) begin
            drv = ~(3'b001 << ((f > 2) ? 2 : f));
            @(negedge clk) tach[f] = tmin[f] + 16'h0001;
            @(negedge clk) tach[f] = tmin[f];
            rd(8'h42, 8'h00);
            drv = 3'b111;
            @(negedge clk) tach[f] = tmin[f] + 16'h0001;
            @(negedge clk) tach[f] = tmin[f];
            rd(8'h41, 8'h80);
            rd(8'h42, 8'h04 << f);
            rd(8'h42, 8'h00);
        end
        @(negedge clk) ovx = 1;
        @(negedge clk) ovx = 0;
        rd(8'h42, 8'h02);
        rd(8'h42, 8'h02);
        ovh = 1;
        rd(8'h42, 8'h02);
        rd(8'h42, 8'h00);
        {d1, d2} = 2'b11;
        rd(8'h41, 8'h80);
        rd(8'h42, 8'hC0);
        {d1, d2} = 2'b00;
        rd(8'h42, 8'hC0);
        rd(8'h42, 8'h00);
        $display("fan and fault test done");
        mode = 2'b01;
        tmsf_host_model_inst.access(1'b1, 8'h42, 8'hFF);
        chk_gpio(1'b1);
        rd(8'h42, 8'h20);
        tmsf_host_model_inst.access(1'b1, 8'h41, 8'hFF);
        rd(8'h41, 8'h80);
        rd(8'h10, 8'h00);
        // unused pin function drops the stored bit and the level
        mode = 2'b11;
        rd(8'h42, 8'h00);
        chk_gpio(1'b0);
        mode = 2'b01;
        tmsf_host_model_inst.access(1'b1, 8'h42, 8'hFF);
        chk_gpio(1'b1);
        tmsf_host_model_inst.access(1'b1, 8'h42, 8'h00);
        chk_gpio(1'b0);
        {mode, tl} = {2'b10, 8'h40};
        @(negedge clk) tm = 8'h40;
        rd(8'h42, 8'h00);
        tm = 8'h41;
        rd(8'h42, 8'h20);
        tm = 8'h00;
        rd(8'h42, 8'h20);
        rd(8'h42, 8'h00);
        repeat (2) @(negedge clk);
        chk("pending", 8'h00, 8'(exp_q.size()));
        $display("pin mode test done");
        // frozen enable: a one-cycle fault and a read are both lost
        @(negedge clk) en = 1'b0;
        @(negedge clk) d1 = 1'b1;
        @(negedge clk) d1 = 1'b0;
        tmsf_host_model_inst.access(1'b0, 8'h42, 8'h00);
        en = 1'b1;
        rd(8'h42, 8'h00);
        repeat (2) @(negedge clk);
        chk("pending", 8'h00, 8'(exp_q.size()));
        $display("enable test done");
        final_report();
    end
endmodule
bind tmsf_status_flags tmsf_status_flags_asserts #(.TIME_W(TIME_W)) asserts_inst (.*);
